// ---- hw/insn_exec_pkg.sv ----
package insn_exec_pkg;
    localparam int WORD_W          = 32;
    localparam int DWORD_W         = 64;
    localparam int OPC_POS         = 26;
    localparam int SRC_ONE_POS     = 21;
    localparam int SRC_TWO_POS     = 16;
    localparam int IMM_POS         = 0;
    localparam int FUNCT_POS       = 0;
    localparam int CACHE_SEL_POS   = 16;
    localparam int CACHE_ACT_POS   = 18;
    localparam int WAY_SEL_BIT     = 31;
    localparam int LINK_OFFSET     = 8;
    localparam int BRANCH_SHIFT    = 2;
    localparam int WAY_INDEX_DROP  = 2;
    localparam logic [5:0] OPC_REG_IMM  = 6'h01;
    localparam logic [5:0] OPC_SPECIAL  = 6'h00;
    localparam logic [5:0] OPC_BNE      = 6'h05;
    localparam logic [5:0] OPC_BRANCH_NOT_EQUAL_LIKELY     = 6'h15;
    localparam logic [5:0] OPC_CACHE    = 6'h2F;
    localparam logic [5:0] FN_BREAK     = 6'h0D;
    localparam logic [4:0] RI_NEG_LIKELY      = 5'h02;
    localparam logic [4:0] RI_NEG_LINK        = 5'h10;
    localparam logic [4:0] RI_NEG_LINK_LIKELY = 5'h12;
    localparam logic [4:0] LINK_REG_IDX = 5'h1F;
    localparam logic [1:0] CACHE_INSN   = 2'h0;
    localparam logic [1:0] CACHE_DATA   = 2'h1;
    localparam logic [2:0] ACT_IDX_INV   = 3'h0;
    localparam logic [2:0] ACT_LOAD_TAG  = 3'h1;
    localparam logic [2:0] ACT_STORE_TAG = 3'h2;
    localparam logic [2:0] ACT_DIRTY_EXC = 3'h3;
    localparam logic [2:0] ACT_HIT_INV   = 3'h4;
    localparam logic [2:0] ACT_HIT_WBI   = 3'h5;
    localparam logic [2:0] ACT_HIT_WB    = 3'h6;
    localparam logic [2:0] ACT_FETCH_LCK = 3'h7;

    typedef enum logic [2:0] {
        CS_IDLE,
        CS_XLATE,
        CS_LOOKUP,
        CS_ACT,
        CS_WB,
        CS_DONE
    } cache_state_t;
endpackage

// ---- hw/tag_hold.sv ----
`timescale 1ns/1ps
// Holds the tag of the looked-up line so write-back uses the cached address.
module tag_hold #(
    parameter int W = 64
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Write side
    input  wire logic         wr_en,
    input  wire logic [W-1:0] wr_data,
    // Read side
    output logic      [W-1:0] rd_data
);
    logic [W-1:0] data_reg;
    logic [W-1:0] data_next;

    always_comb begin
        data_next = wr_en ? wr_data : data_reg;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_reg <= '0;
        end else begin
            data_reg <= data_next;
        end
    end

    assign rd_data = data_reg;
endmodule // tag_hold

// ---- hw/branch_break_cacheop_exec.sv ----
`timescale 1ns/1ps
module branch_break_cacheop_exec
    import insn_exec_pkg::*;
#(
    parameter int CACHE_SIZE_LOG2 = 14,
    parameter int LINE_SIZE_LOG2  = 4,
    parameter bit TWO_WAY         = 1'b0
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Issue from the pipeline
    input  wire logic               issue_valid,
    input  wire logic [WORD_W-1:0]  insn_word,
    input  wire logic [DWORD_W-1:0] insn_pc,
    input  wire logic [DWORD_W-1:0] src_one_val,
    input  wire logic [DWORD_W-1:0] src_two_val,
    input  wire logic               mode_64,
    input  wire logic               kernel_mode,
    input  wire logic               cp0_usable,
    // Branch results
    output logic                    branch_valid,
    output logic                    branch_taken,
    output logic [DWORD_W-1:0]      branch_target,
    output logic                    nullify_slot,
    output logic                    link_we,
    output logic [4:0]              link_idx,
    output logic [DWORD_W-1:0]      link_data,
    // Exceptions
    output logic                    break_exc,
    output logic                    cp_unusable_exc,
    output logic                    tlb_refill_exc,
    output logic                    tlb_invalid_exc,
    output logic                    tlb_modified_exc,
    // TLB port
    output logic                    tlb_req,
    output logic [DWORD_W-1:0]      tlb_vaddr,
    input  wire logic               tlb_ack,
    input  wire logic               tlb_miss,
    input  wire logic               tlb_inval,
    input  wire logic [DWORD_W-1:0] tlb_paddr,
    // Cache port
    output logic                    cache_req,
    output logic [1:0]              cache_sel,
    output logic [2:0]              cache_action,
    output logic                    cache_by_index,
    output logic [DWORD_W-1:0]      cache_index,
    output logic                    cache_way,
    output logic [DWORD_W-1:0]      cache_paddr,
    input  wire logic               cache_ack,
    input  wire logic               cache_hit,
    input  wire logic               cache_dirty,
    input  wire logic [DWORD_W-1:0] cache_tag_addr,
    // Write-back port
    output logic                    wb_req,
    output logic [DWORD_W-1:0]      wb_addr,
    input  wire logic               wb_ack,
    // Completion
    output logic                    cache_busy,
    output logic                    cache_done
);
    // Refused at elaboration: the way bit must stay above the index field.
    if (LINE_SIZE_LOG2 < 2 || CACHE_SIZE_LOG2 <= LINE_SIZE_LOG2 + 2 ||
        CACHE_SIZE_LOG2 > 30) begin : g_bad_geometry
        $error("Cache geometry parameters out of range.");
    end

    function automatic logic [DWORD_W-1:0] sext16(input logic [15:0] v);
        sext16 = {{(DWORD_W-16){v[15]}}, v};
    endfunction

    // Instruction fields.
    logic [5:0]  opc;
    logic [4:0]  src_one_idx;
    logic [4:0]  sub_code;
    logic [15:0] imm;
    logic [5:0]  funct;
    assign opc         = insn_word[OPC_POS +: 6];
    assign src_one_idx = insn_word[SRC_ONE_POS +: 5];
    assign sub_code    = insn_word[SRC_TWO_POS +: 5];
    assign imm         = insn_word[IMM_POS +: 16];
    assign funct       = insn_word[FUNCT_POS +: 6];

    logic is_neg_link;
    logic is_neg_link_likely;
    logic is_neg_likely;
    logic is_bne;
    logic is_branch_not_equal_likely;
    logic is_break;
    logic is_cache;
    always_comb begin
        is_neg_link        = opc == OPC_REG_IMM && sub_code == RI_NEG_LINK;
        is_neg_link_likely = opc == OPC_REG_IMM &&
                             sub_code == RI_NEG_LINK_LIKELY;
        is_neg_likely      = opc == OPC_REG_IMM && sub_code == RI_NEG_LIKELY;
        is_bne             = opc == OPC_BNE;
        is_branch_not_equal_likely            = opc == OPC_BRANCH_NOT_EQUAL_LIKELY;
        is_break           = opc == OPC_SPECIAL && funct == FN_BREAK;
        is_cache           = opc == OPC_CACHE;
    end

    // Branch evaluation; results register so redirection follows one slot.
    logic               neg_bit;
    logic               cond;
    logic               any_branch;
    logic               likely;
    logic               linking;
    logic               br_valid_reg, br_valid_next;
    logic               br_taken_reg, br_taken_next;
    logic [DWORD_W-1:0] br_target_reg, br_target_next;
    logic               null_reg, null_next;
    logic               link_we_reg, link_we_next;
    logic [DWORD_W-1:0] link_data_reg, link_data_next;
    logic               brk_reg, brk_next;

    always_comb begin
        neg_bit    = mode_64 ? src_one_val[DWORD_W-1] :
                               src_one_val[WORD_W-1];
        linking    = is_neg_link || is_neg_link_likely;
        likely     = is_neg_link_likely || is_neg_likely || is_branch_not_equal_likely;
        any_branch = linking || is_neg_likely || is_bne || is_branch_not_equal_likely;
        // Full-width compare: upper half of 32-bit values is sign copy.
        cond = (is_bne || is_branch_not_equal_likely) ? (src_one_val != src_two_val)
                                   : neg_bit;
        br_valid_next  = issue_valid && any_branch;
        br_taken_next  = issue_valid && any_branch && cond;
        // Delay-slot address is PC plus 4.
        br_target_next = insn_pc + DWORD_W'(4) +
                         (sext16(imm) << BRANCH_SHIFT);
        null_next      = issue_valid && likely && !cond;
        // No check on source index: link-register source runs untrapped.
        link_we_next   = issue_valid && linking;
        link_data_next = insn_pc + DWORD_W'(LINK_OFFSET);
        // Only the event leaves; the code field has no path out.
        brk_next       = issue_valid && is_break;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            br_valid_reg  <= 1'b0;
            br_taken_reg  <= 1'b0;
            br_target_reg <= '0;
            null_reg      <= 1'b0;
            link_we_reg   <= 1'b0;
            link_data_reg <= '0;
            brk_reg       <= 1'b0;
        end else begin
            br_valid_reg  <= br_valid_next;
            br_taken_reg  <= br_taken_next;
            br_target_reg <= br_target_next;
            null_reg      <= null_next;
            link_we_reg   <= link_we_next;
            link_data_reg <= link_data_next;
            brk_reg       <= brk_next;
        end
    end

    assign branch_valid  = br_valid_reg;
    assign branch_taken  = br_taken_reg;
    assign branch_target = br_target_reg;
    assign nullify_slot  = null_reg;
    assign link_we       = link_we_reg;
    assign link_idx      = LINK_REG_IDX;
    assign link_data     = link_data_reg;
    assign break_exc     = brk_reg;

    // Cache maintenance sequencer.
    cache_state_t       st_reg, st_next;
    logic [DWORD_W-1:0] va_reg, va_next;
    logic [1:0]         sel_reg, sel_next;
    logic [2:0]         act_reg, act_next;
    logic               byidx_reg, byidx_next;
    logic [DWORD_W-1:0] pa_reg, pa_next;
    logic               cpu_reg, cpu_next;
    logic               refill_reg, refill_next;
    logic               inval_reg, inval_next;
    logic               tag_we;
    logic [DWORD_W-1:0] held_tag;
    logic               needs_wb;
    logic [DWORD_W-1:0] idx_mask;
    logic               start;

    always_comb begin
        idx_mask = ((DWORD_W'(1) << (TWO_WAY ? CACHE_SIZE_LOG2 - WAY_INDEX_DROP
                    : CACHE_SIZE_LOG2)) - DWORD_W'(1)) &
                   ~((DWORD_W'(1) << LINE_SIZE_LOG2) - DWORD_W'(1));
        start = issue_valid && is_cache && st_reg == CS_IDLE;
        // Index actions are the low three codes.
        needs_wb = (act_reg == ACT_IDX_INV && sel_reg == CACHE_DATA) ||
                   act_reg == ACT_HIT_WBI || act_reg == ACT_HIT_WB ||
                   act_reg == ACT_DIRTY_EXC;
        st_next     = st_reg;
        va_next     = va_reg;
        sel_next    = sel_reg;
        act_next    = act_reg;
        byidx_next  = byidx_reg;
        pa_next     = pa_reg;
        cpu_next    = 1'b0;
        refill_next = 1'b0;
        inval_next  = 1'b0;
        tag_we      = 1'b0;
        case (st_reg)
            CS_IDLE: begin
                if (start) begin
                    if (!kernel_mode && !cp0_usable) begin
                        cpu_next = 1'b1;
                    end else begin
                        va_next    = src_one_val + sext16(imm);
                        sel_next   = sub_code[1:0];
                        act_next   = sub_code[4:2];
                        byidx_next = sub_code[4:2] <= ACT_STORE_TAG;
                        // Unlisted pairs are issued as-is; result undefined.
                        st_next    = CS_XLATE;
                    end
                end
            end
            CS_XLATE: begin
                if (tlb_ack) begin
                    pa_next = tlb_paddr;
                    // Modified is never checked here.
                    refill_next = tlb_miss;
                    inval_next  = tlb_inval && !tlb_miss;
                    st_next = (tlb_miss || tlb_inval) ? CS_DONE : CS_LOOKUP;
                end
            end
            CS_LOOKUP: begin
                if (cache_ack) begin
                    tag_we = 1'b1;
                    if (!byidx_reg && !cache_hit) begin
                        st_next = CS_DONE;
                    end else if (needs_wb && cache_dirty) begin
                        st_next = CS_WB;
                    end else begin
                        st_next = CS_ACT;
                    end
                end
            end
            CS_WB: begin
                if (wb_ack) begin
                    st_next = CS_ACT;
                end
            end
            CS_ACT: begin
                st_next = CS_DONE;
            end
            CS_DONE: begin
                st_next = CS_IDLE;
            end
            default: begin
                st_next = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg     <= CS_IDLE;
            va_reg     <= '0;
            sel_reg    <= CACHE_INSN;
            act_reg    <= ACT_IDX_INV;
            byidx_reg  <= 1'b0;
            pa_reg     <= '0;
            cpu_reg    <= 1'b0;
            refill_reg <= 1'b0;
            inval_reg  <= 1'b0;
        end else begin
            st_reg     <= st_next;
            va_reg     <= va_next;
            sel_reg    <= sel_next;
            act_reg    <= act_next;
            byidx_reg  <= byidx_next;
            pa_reg     <= pa_next;
            cpu_reg    <= cpu_next;
            refill_reg <= refill_next;
            inval_reg  <= inval_next;
        end
    end

    tag_hold #(
        .W (DWORD_W)
    ) u_tag_hold (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_en   (tag_we),
        .wr_data (cache_tag_addr),
        .rd_data (held_tag)
    );

    assign cp_unusable_exc  = cpu_reg;
    assign tlb_refill_exc   = refill_reg;
    assign tlb_invalid_exc  = inval_reg;
    assign tlb_modified_exc = 1'b0;
    assign tlb_req          = st_reg == CS_XLATE;
    assign tlb_vaddr        = va_reg;
    assign cache_req        = st_reg == CS_LOOKUP;
    assign cache_sel        = sel_reg;
    assign cache_action     = act_reg;
    assign cache_by_index   = byidx_reg;
    assign cache_index      = va_reg & idx_mask;
    assign cache_way        = TWO_WAY & va_reg[WAY_SEL_BIT];
    assign cache_paddr      = pa_reg;
    assign wb_req           = st_reg == CS_WB;
    assign wb_addr          = held_tag;
    assign cache_busy       = st_reg != CS_IDLE;
    assign cache_done       = st_reg == CS_DONE;
endmodule // branch_break_cacheop_exec

// ---- tb/branch_break_cacheop_exec_sva.sv ----
`timescale 1ns/1ps
module branch_break_cacheop_exec_sva
    import insn_exec_pkg::*;
#(
    parameter int CACHE_SIZE_LOG2 = 14,
    parameter int LINE_SIZE_LOG2  = 4,
    parameter bit TWO_WAY         = 1'b0
) (
    // Clock, reset and issue
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        issue_valid,
    input wire logic [31:0] insn_word,
    input wire logic [63:0] insn_pc,
    input wire logic [63:0] src_one_val,
    input wire logic [63:0] src_two_val,
    input wire logic        kernel_mode,
    input wire logic        cp0_usable,
    // Results
    input wire logic        branch_valid,
    input wire logic        branch_taken,
    input wire logic [63:0] branch_target,
    input wire logic        nullify_slot,
    input wire logic        link_we,
    input wire logic [4:0]  link_idx,
    input wire logic [63:0] link_data,
    input wire logic        break_exc,
    input wire logic        cp_unusable_exc,
    input wire logic        tlb_refill_exc,
    input wire logic        tlb_modified_exc,
    // Memory side
    input wire logic        tlb_req,
    input wire logic        tlb_ack,
    input wire logic        tlb_miss,
    input wire logic        cache_req,
    input wire logic [63:0] cache_tag_addr,
    input wire logic        wb_req,
    input wire logic        wb_ack,
    input wire logic [63:0] wb_addr,
    input wire logic        cache_busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    function automatic logic [63:0] off4(input logic [31:0] w);
        return {{46{w[15]}}, w[15:0], 2'b00};
    endfunction

    AST_TLB_MOD: assert property (!tlb_modified_exc)
        else $error("tlb modified raised");
    AST_LINK: assert property (link_we |-> link_idx == LINK_REG_IDX
        && link_data == $past(insn_pc) + 64'h8) else $error("bad link");
    AST_TARGET: assert property (branch_valid |-> branch_target ==
        $past(insn_pc) + 64'h4 + off4($past(insn_word)))
        else $error("bad target");
    AST_BREAK: assert property (issue_valid && insn_word[5:0] == FN_BREAK
        && insn_word[31:26] == OPC_SPECIAL |=> break_exc)
        else $error("no break trap");
    AST_BNE: assert property (issue_valid && insn_word[31:26] == OPC_BNE
        |=> branch_valid && branch_taken ==
        ($past(src_one_val) != $past(src_two_val))) else $error("bne");
    AST_NULL: assert property (nullify_slot |-> branch_valid
        && !branch_taken) else $error("nullify while taken");
    AST_CPU: assert property (issue_valid && !cache_busy && !kernel_mode
        && !cp0_usable && insn_word[31:26] == OPC_CACHE
        |=> cp_unusable_exc && !tlb_req ##1 !tlb_req) else $error("cpu");
    AST_REFILL: assert property (tlb_req && tlb_ack && tlb_miss
        |=> tlb_refill_exc && !cache_req) else $error("refill");
    AST_WB: assert property ($rose(wb_req) |->
        wb_addr == $past(cache_tag_addr)) else $error("wb address");

    COV_WB: cover property (wb_req && wb_ack);
    COV_NULL: cover property (nullify_slot);
    COV_CPU: cover property (cp_unusable_exc);
endmodule // branch_break_cacheop_exec_sva

bind branch_break_cacheop_exec branch_break_cacheop_exec_sva #(
    .CACHE_SIZE_LOG2(CACHE_SIZE_LOG2),
    .LINE_SIZE_LOG2(LINE_SIZE_LOG2),
    .TWO_WAY(TWO_WAY)
) u_sva (.*);

// ---- tb/mem_side_model.sv ----
`timescale 1ns/1ps
module mem_side_model (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Requests from the block
    input wire logic        tlb_req,
    input wire logic        cache_req,
    input wire logic        wb_req,
    // Behaviour set by the bench
    input wire logic        m_miss,
    input wire logic        m_hit,
    input wire logic        m_dirty,
    input wire logic        m_inval,
    input wire logic [3:0]  m_dly,
    input wire logic [63:0] m_tag,
    // Answers
    output logic            tlb_ack,
    output logic            tlb_miss,
    output logic            tlb_inval,
    output logic [63:0]     tlb_paddr,
    output logic            cache_ack,
    output logic            cache_hit,
    output logic            cache_dirty,
    output logic [63:0]     cache_tag_addr,
    output logic            wb_ack
);
    logic [3:0] cnt_reg;
    wire logic any_ack = tlb_ack | cache_ack | wb_ack;
    wire logic req = tlb_req | cache_req | wb_req;
    wire logic go = req && !any_ack && cnt_reg >= m_dly;

    // Data is inverted outside an answer so stale values never pass.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 4'h0;
            tlb_ack <= 1'b0;
            cache_ack <= 1'b0;
            wb_ack <= 1'b0;
        end else begin
            cnt_reg <= (req && !any_ack && !go) ? cnt_reg + 4'h1 : 4'h0;
            tlb_ack <= go & tlb_req;
            cache_ack <= go & cache_req;
            wb_ack <= go & wb_req;
        end
    end
    always_ff @(posedge ref_clk) begin
        tlb_miss <= go & tlb_req & m_miss;
        tlb_inval <= go & tlb_req & m_inval;
        tlb_paddr <= go ? m_tag ^ 64'hFFFF_0000 : ~m_tag;
        cache_hit <= go & m_hit;
        cache_dirty <= go & m_dirty;
        cache_tag_addr <= go ? m_tag : ~m_tag;
    end
endmodule // mem_side_model

// ---- tb/branch_break_cacheop_exec_tb.sv ----
`timescale 1ns/1ps
module branch_break_cacheop_exec_tb
    import insn_exec_pkg::*;
;
    logic        ref_clk, rst, issue_valid, mode_64, kernel_mode, cp0_usable;
    logic [31:0] insn_word;
    logic [63:0] insn_pc, src_one_val, src_two_val, branch_target, link_data;
    logic        branch_valid, branch_taken, nullify_slot, link_we, break_exc;
    logic [4:0]  link_idx;
    logic        cp_unusable_exc, tlb_refill_exc, tlb_invalid_exc;
    logic        tlb_modified_exc, tlb_req, tlb_ack, tlb_miss, tlb_inval;
    logic [63:0] tlb_vaddr, tlb_paddr, cache_index, cache_paddr;
    logic [63:0] cache_tag_addr, wb_addr, m_tag, got_wba;
    logic        cache_req, cache_by_index, cache_way, cache_ack, cache_hit;
    logic        cache_dirty, wb_req, wb_ack, cache_busy, cache_done;
    logic [1:0]  cache_sel, got_sel;
    logic [2:0]  cache_action, got_act;
    logic        m_miss, m_hit, m_dirty, seen_wb, seen_ref, got_idx;
    logic        m_inval, seen_inv;
    logic [63:0] got_cix, got_pa;
    logic [3:0]  m_dly;
    int          bad_count, n_checks, cycles;

    branch_break_cacheop_exec dut (.*);
    mem_side_model u_mem (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic give_verdict;
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp, input string s);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s", $time, s);
        end
    endtask

    task automatic chk64(input logic [63:0] got, exp, input string s);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s", $time, s);
        end
    endtask

    // Outputs are sampled just after the answering edge has settled.
    task automatic issue(input logic [31:0] w, input logic [63:0] pc, a, b,
                         input logic [2:0] ctl);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        insn_word <= w;
        insn_pc <= pc;
        src_one_val <= a;
        src_two_val <= b;
        {mode_64, kernel_mode, cp0_usable} <= ctl;
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        #1;
    endtask

    task automatic t_neg_link;
        logic [63:0] pc;
        pc = 64'h0000_0000_0040_1000;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 2; k++) begin
                issue({OPC_REG_IMM, LINK_REG_IDX, RI_NEG_LINK, 16'hFFF0}, pc,
                      k ? 64'h8000_0000_0000_0000 : 64'h8000_0000, 64'h0,
                      {m[0], 2'h0});
                chk1(branch_taken, m == k, "sign test");
                chk1(link_we, 1'b1, "link write");
                chk64(link_data, pc + 64'h8, "link data");
                chk64(branch_target, pc - 64'h3C, "target");
                chk1(break_exc, 1'b0, "trap on link source");
            end
        end
    endtask

    task automatic t_likely;
        logic [31:0] w [3];
        w = '{{OPC_REG_IMM, 5'h04, RI_NEG_LIKELY, 16'h0010},
              {OPC_REG_IMM, 5'h04, RI_NEG_LINK_LIKELY, 16'h0010},
              {OPC_BRANCH_NOT_EQUAL_LIKELY, 5'h04, 5'h05, 16'h0010}};
        for (int i = 0; i < 3; i++) begin
            for (int t = 0; t < 2; t++) begin
                issue(w[i], 64'h2000, t ? 64'hFFFF_FFFF_8000_0000 : 64'h0,
                      64'h0, 3'h0);
                chk1(nullify_slot, t == 0, "nullify");
                chk1(branch_taken, t == 1, "likely taken");
            end
        end
    endtask

    task automatic t_bne;
        issue({OPC_BNE, 5'h01, 5'h02, 16'h0004}, 64'h100,
              64'h8000_0000_0000_0000, 64'h0, 3'h0);
        chk1(branch_taken, 1'b1, "bne upper bits");
        issue({OPC_BNE, 5'h01, 5'h02, 16'h0004}, 64'h100, 64'h5, 64'h5, 3'h0);
        chk1(branch_taken, 1'b0, "bne equal");
        chk1(break_exc, 1'b0, "bne trap");
    endtask

    task automatic t_break;
        issue({OPC_SPECIAL, 20'hABCDE, FN_BREAK}, 64'h300, 64'h0, 64'h0, 3'h0);
        chk1(break_exc, 1'b1, "break");
        chk1(link_we, 1'b0, "break writes register");
    endtask

    task automatic cop(input logic [4:0] sub, input logic [2:0] ctl);
        int n;
        seen_wb = 1'b0;
        seen_ref = 1'b0;
        seen_inv = 1'b0;
        issue({OPC_CACHE, 5'h02, sub, 16'hFFFC}, 64'h0, 64'h1000, 64'h0, ctl);
        chk64(tlb_vaddr, 64'h0FFC, "vaddr");
        n = 0;
        while (cache_done !== 1'b1 && n < 40) begin
            if (cache_req === 1'b1) {got_sel, got_act, got_idx} =
                {cache_sel, cache_action, cache_by_index};
            if (cache_req === 1'b1) {got_cix, got_pa} =
                {cache_index, cache_paddr};
            if (wb_req === 1'b1) {seen_wb, got_wba} = {1'b1, wb_addr};
            if (tlb_refill_exc === 1'b1) seen_ref = 1'b1;
            @(posedge ref_clk);
            #1;
            n++;
        end
        // TLB faults pulse on the same edge that raises done.
        if (tlb_refill_exc === 1'b1) seen_ref = 1'b1;
        if (tlb_invalid_exc === 1'b1) seen_inv = 1'b1;
        chk1(cache_done, 1'b1, "cache done");
    endtask

    task automatic t_cache_acts;
        for (int a = 0; a < 8; a++) begin
            for (int s = 0; s < 2; s++) begin
                cop({a[2:0], 1'b0, s[0]}, 3'h3);
                chk1(got_sel === s[1:0], 1'b1, "cache select");
                chk1(got_act === a[2:0], 1'b1, "action");
                chk1(got_idx, a <= 2, "index op");
                chk64(got_cix, 64'h0FF0, "index bits");
                chk64(got_pa, m_tag ^ 64'hFFFF_0000, "paddr");
            end
        end
    endtask

    task automatic t_cache_faults;
        issue({OPC_CACHE, 5'h02, 5'h01, 16'h0}, 64'h0, 64'h40, 64'h0, 3'h0);
        chk1(cp_unusable_exc, 1'b1, "unusable");
        chk1(tlb_req, 1'b0, "op after unusable");
        repeat (3) @(posedge ref_clk);
        cop({ACT_HIT_INV, CACHE_DATA}, 3'h1);
        chk1(seen_ref, 1'b0, "user with usable");
        m_miss = 1'b1;
        cop({ACT_IDX_INV, CACHE_INSN}, 3'h3);
        chk1(seen_ref, 1'b1, "refill");
        {m_miss, m_inval} = 2'b01;
        cop({ACT_HIT_INV, CACHE_INSN}, 3'h3);
        chk1(seen_inv, 1'b1, "tlb invalid");
        m_inval = 1'b0;
        {m_dly, m_dirty} = {4'h3, 1'b1};
        cop({ACT_HIT_WB, CACHE_DATA}, 3'h3);
        chk1(seen_wb, 1'b1, "write-back on hit");
        chk64(got_wba, m_tag, "write-back address");
        m_hit = 1'b0;
        cop({ACT_HIT_WB, CACHE_DATA}, 3'h3);
        chk1(seen_wb, 1'b0, "write-back on miss");
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        {rst, issue_valid, mode_64, kernel_mode, cp0_usable} = 5'h10;
        {insn_word, insn_pc, src_one_val, src_two_val} = '0;
        {m_miss, m_hit, m_dirty, m_dly} = 7'h20;
        m_inval = 1'b0;
        m_tag = 64'h0000_0000_1234_5670;
        {bad_count, n_checks, cycles} = '0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_neg_link();
        t_likely();
        t_bne();
        t_break();
        t_cache_acts();
        t_cache_faults();
        give_verdict();
    end
endmodule // branch_break_cacheop_exec_tb
